// file: verilog/spir_pkg.sv
// Purpose: shared constants and carriers for the protocol-information responder
// Assumes: byte-wide reply stream, one byte per accepted beat
// Notes:   lengths follow the reply image header layouts
package spir_pkg;

	localparam logic [7:0]  SPIR_PROTO_INFO   = 8'h00;
	localparam logic [15:0] SPIR_SPEC_LIST    = 16'h0000;
	localparam logic [15:0] SPIR_SPEC_CERT    = 16'h0001;
	localparam logic [15:0] SPIR_SPEC_COMPL   = 16'h0002;
	localparam logic [7:0]  SPIR_PAD_BYTE     = 8'h00;

	// Header sizes of each reply image
	localparam logic [31:0] SPIR_LIST_HDR     = 32'h0000_0008;
	localparam logic [31:0] SPIR_CERT_HDR     = 32'h0000_0004;
	localparam logic [31:0] SPIR_COMPL_HDR    = 32'h0000_0004;
	localparam logic [31:0] SPIR_DESC_HDR     = 32'h0000_0008;
	localparam logic [15:0] SPIR_DESC_CRYPTO  = 16'h0001;

	// Field positions (byte offsets) inside the images
	localparam logic [31:0] SPIR_LIST_LEN_HI  = 32'h0000_0006;
	localparam logic [31:0] SPIR_LIST_LEN_LO  = 32'h0000_0007;
	localparam logic [31:0] SPIR_CERT_LEN_HI  = 32'h0000_0002;
	localparam logic [31:0] SPIR_CERT_LEN_LO  = 32'h0000_0003;
	localparam logic [31:0] SPIR_DESC_TYPE_HI = 32'h0000_0000;
	localparam logic [31:0] SPIR_DESC_TYPE_LO = 32'h0000_0001;
	localparam logic [31:0] SPIR_DESC_LEN_HI  = 32'h0000_0006;
	localparam logic [31:0] SPIR_DESC_LEN_LO  = 32'h0000_0007;

	typedef struct packed {
		logic [7:0]  protocol;
		logic [15:0] specific;
		logic [31:0] alloc_len;
	} spir_cmd_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} spir_beat_t;

	typedef enum logic [2:0] {
		SPIR_IDLE = 3'b001,
		SPIR_SEND = 3'b010,
		SPIR_DONE = 3'b100
	} spir_state_t;

	typedef enum logic [1:0] {
		SPIR_IMG_LIST  = 2'h0,
		SPIR_IMG_CERT  = 2'h1,
		SPIR_IMG_COMPL = 2'h2
	} spir_img_t;

endpackage

// file: verilog/spir_responder.sv
// Purpose: protocol-information reply generator (supported list,
//          certificate data, compliance information)
// Assumes: inputs synchronous to clk_in; certificate and descriptor
//          content fetched by byte index from outside stores
// Notes:   one command at a time; reply is a byte stream with valid/ready
//          zero allocation ends at once with no beats
//          a malformed protocol table is cut to its leading ascending run starting at 00h
//          certificate length is captured when a command is taken
//          only one compliance descriptor is built; its body is fetched
//          stalls only hold the beat register, the image is not buffered
//
// Operation
// RQ1 - Protocol 00h requests served alone, no earlier out-command state.
// RQ2 - Protocol 00h is always accepted whenever any in-command is accepted.
// RQ3 - Code 0000h list, 0001h certificate, 0002h compliance; others rejected.
// RQ4 - Each command restarts the reply at byte 0, nothing carried over.
// RQ5 - List reply: bytes 0-5 zero, 6-7 list length m-7, entries from 8.
// RQ6 - Protocol entries listed once, strictly ascending, first entry 00h.
// RQ7 - Bytes past the meaningful content up to allocation length are 00h.
// RQ8 - Certificate reply: bytes 0-1 zero, 2-3 length m-3, content from 4.
// RQ9 - No certificate held means a certificate length of 0000h.
// RQ10 - Certificate length is the total of all concatenated certificates.
// RQ11 - Certificate content is X.509 public-key or attribute, per capability.
// RQ12 - Compliance reply: bytes 0-3 length m-3, descriptors from byte 4.
// RQ13 - Descriptor: type 0001h, two zero bytes, length in 4-7, then body.
// RQ14 - Transfer stops at allocation length; never more bytes than requested.
`timescale 1ns/1ns
`default_nettype none

module spir_responder #(
	parameter int NUM_PROTO = 2,
	parameter logic [NUM_PROTO*8-1:0] PROTO_LIST = 16'hef_00,
	parameter logic [15:0] DESC_BODY_LEN = 16'h0208,
	parameter logic        COMPL_SUPPORTED = 1'b1
) (
	input  wire logic                clk_in,
	input  wire logic                resetn_in,
	input  wire spir_pkg::spir_cmd_t cmd_in,
	input  wire logic                cmd_valid_in,
	output logic                     cmd_ready_out,
	output logic                     cmd_reject_out,
	input  wire logic [15:0]         cert_len_in,
	output logic [15:0]              cert_idx_out,
	input  wire logic [7:0]          cert_byte_in,
	output logic [15:0]              desc_idx_out,
	input  wire logic [7:0]          desc_byte_in,
	output spir_pkg::spir_beat_t     beat_out,
	input  wire logic                beat_ready_in,
	output logic                     done_out
);
	import spir_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release

	// Synchronised release so every flop leaves reset on one edge
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		spir_state_t state;
		spir_img_t   img;
		logic [31:0] pos;
		logic [31:0] alloc;
		logic [31:0] content;
		logic [15:0] cert_len;
		logic        reject;
		spir_beat_t  beat;
	} spir_regs_t;

	spir_regs_t s_q;
	spir_regs_t s_d;

	////////////////////////////////////////////////////////////////////////
	// Protocol table check: ascending, first is 00h

	logic [NUM_PROTO-1:0] order_ok;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PROTO; gi++) begin : g_order
			if (gi == 0) begin : g_first
				assign order_ok[gi] =
					(PROTO_LIST[7:0] == SPIR_PROTO_INFO); // see RQ6
			end else begin : g_next
				assign order_ok[gi] = PROTO_LIST[gi*8 +: 8] >
					PROTO_LIST[(gi-1)*8 +: 8]; // see RQ6
			end
		end
	endgenerate

	// A malformed table is trimmed to the leading valid run
	// Entries after a fault stay hidden so the list never goes out of order
	logic [15:0] list_cnt;
	always_comb begin
		list_cnt = 16'h0000;
		for (int i = NUM_PROTO - 1; i >= 0; i--) begin
			if (!order_ok[i]) begin
				list_cnt = 16'(i);
			end
		end
		if (&order_ok) begin
			list_cnt = 16'(NUM_PROTO);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply byte at current position

	logic [31:0] compl_len;
	logic [31:0] desc_pos;
	logic [31:0] body_pos;
	logic [31:0] list_idx;
	logic [31:0] pos_nx;
	logic [7:0]  img_byte;

	// Descriptor length field counts the bytes after byte 7
	assign compl_len = SPIR_DESC_HDR + {16'h0000, DESC_BODY_LEN}; // see RQ12
	assign desc_pos  = s_q.pos - SPIR_COMPL_HDR;
	assign body_pos  = desc_pos - SPIR_DESC_HDR;
	assign list_idx  = s_q.pos - SPIR_LIST_HDR;

	always_comb begin
		img_byte = SPIR_PAD_BYTE;
		// Short images are padded out to the allocation length
		if (s_q.pos >= s_q.content) begin
			img_byte = SPIR_PAD_BYTE; // see RQ7
		end else begin
			case (s_q.img)
				SPIR_IMG_LIST: begin
					if (s_q.pos == SPIR_LIST_LEN_HI) begin
						img_byte = list_cnt[15:8]; // see RQ5
					end else if (s_q.pos == SPIR_LIST_LEN_LO) begin
						img_byte = list_cnt[7:0]; // see RQ5
					end else if (s_q.pos >= SPIR_LIST_HDR) begin
						img_byte = PROTO_LIST[list_idx * 8 +: 8]; // see RQ6
					end
				end
				SPIR_IMG_CERT: begin
					if (s_q.pos == SPIR_CERT_LEN_HI) begin
						img_byte = s_q.cert_len[15:8]; // see RQ8, RQ9, RQ10
					end else if (s_q.pos == SPIR_CERT_LEN_LO) begin
						img_byte = s_q.cert_len[7:0]; // see RQ8
					end else if (s_q.pos >= SPIR_CERT_HDR) begin
						img_byte = cert_byte_in; // see RQ11
					end
				end
				SPIR_IMG_COMPL: begin
					if (s_q.pos < SPIR_COMPL_HDR) begin
						// Big-endian: byte 0 carries the top of the count
						img_byte =
							compl_len[(3 - s_q.pos[1:0]) * 8 +: 8]; // see RQ12
					end else if (desc_pos >= SPIR_DESC_HDR) begin
						img_byte = desc_byte_in; // see RQ13
					end else begin
						// Reserved bytes and the length's upper half stay zero
						case (desc_pos)
							SPIR_DESC_TYPE_HI: begin
								img_byte = SPIR_DESC_CRYPTO[15:8]; // see RQ13
							end
							SPIR_DESC_TYPE_LO: begin
								img_byte = SPIR_DESC_CRYPTO[7:0]; // see RQ13
							end
							SPIR_DESC_LEN_HI: begin
								img_byte = DESC_BODY_LEN[15:8]; // see RQ13
							end
							SPIR_DESC_LEN_LO: begin
								img_byte = DESC_BODY_LEN[7:0]; // see RQ13
							end
							default: begin
								img_byte = SPIR_PAD_BYTE; // see RQ13
							end
						endcase
					end
				end
				default: begin
					img_byte = SPIR_PAD_BYTE;
				end
			endcase
		end
	end

	// Store indices count from the first byte after each header
	assign cert_idx_out = 16'(s_q.pos - SPIR_CERT_HDR);
	assign desc_idx_out = 16'(body_pos);

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	logic known_code;
	logic take;
	logic beat_go;
	logic beat_take;
	logic at_end;

	always_comb begin
		known_code = (cmd_in.specific == SPIR_SPEC_LIST) ||
			(cmd_in.specific == SPIR_SPEC_CERT) ||
			(COMPL_SUPPORTED && cmd_in.specific == SPIR_SPEC_COMPL); // see RQ3
	end

	// Low from an accepted take until done has shown, so busy commands wait
	assign cmd_ready_out = (s_q.state == SPIR_IDLE); // see RQ2
	assign take = cmd_valid_in && cmd_ready_out;
	// Beat register empties or is taken this cycle
	assign beat_take = s_q.beat.valid && beat_ready_in;
	assign beat_go   = !s_q.beat.valid || beat_ready_in;
	// Count against alloc, not content: pads fill, truncation cuts short
	assign pos_nx    = s_q.pos + 32'h0000_0001;
	assign at_end    = (pos_nx == s_q.alloc); // see RQ14

	always_comb begin
		s_d = s_q;
		s_d.reject = 1'b0;
		if (beat_take) begin
			s_d.beat.valid = 1'b0;
		end
		case (s_q.state)
			SPIR_IDLE: begin
				if (take) begin
					// Nothing from earlier commands survives here
					s_d.pos = 32'h0000_0000; // see RQ1, RQ4
					s_d.alloc = cmd_in.alloc_len;
					// Captured so a store update cannot bend the header
					s_d.cert_len = cert_len_in; // see RQ9, RQ10
					if (cmd_in.protocol != SPIR_PROTO_INFO || !known_code) begin
						// Refused: one pulse, no data, still idle
						s_d.reject = 1'b1; // see RQ3
					end else if (cmd_in.alloc_len == 32'h0000_0000) begin
						s_d.state = SPIR_DONE; // see RQ14
					end else begin
						s_d.state = SPIR_SEND;
						case (cmd_in.specific)
							SPIR_SPEC_LIST: begin
								s_d.img = SPIR_IMG_LIST;
								s_d.content = SPIR_LIST_HDR +
									{16'h0000, list_cnt}; // see RQ5
							end
							SPIR_SPEC_CERT: begin
								s_d.img = SPIR_IMG_CERT;
								s_d.content = SPIR_CERT_HDR +
									{16'h0000, cert_len_in}; // see RQ8
							end
							default: begin
								s_d.img = SPIR_IMG_COMPL;
								s_d.content = SPIR_COMPL_HDR + compl_len;
							end
						endcase
					end
				end
			end
			SPIR_SEND: begin
				if (beat_go) begin
					s_d.beat.valid = 1'b1;
					s_d.beat.data = img_byte;
					s_d.beat.last = at_end; // see RQ14
					s_d.pos = pos_nx;
					if (at_end) begin
						s_d.state = SPIR_DONE; // see RQ14
					end
				end
			end
			SPIR_DONE: begin
				// Wait for the final byte to drain before the next command
				// and let done_out stand for one cycle
				if (!s_q.beat.valid) begin
					s_d.state = SPIR_IDLE;
				end
			end
			default: begin
				s_d.state = SPIR_IDLE;
			end
		endcase
	end

	// State resets only from the synchronised copy
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{state: SPIR_IDLE, img: SPIR_IMG_LIST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign beat_out       = s_q.beat;
	assign cmd_reject_out = s_q.reject;
	assign done_out       = (s_q.state == SPIR_DONE) && !s_q.beat.valid;

endmodule

`default_nettype wire

// file: sim/spir_host_model.sv
// Purpose: host side of the responder: beat sink and content stores
// Assumes: store bytes follow fixed index patterns
// Notes:   stall_in makes the sink ready only on every other cycle
`timescale 1ns/1ns
`default_nettype none
module spir_host_model (
	input  wire logic        clk_in,
	input  wire logic        stall_in,
	input  wire logic [15:0] cert_idx_in,
	input  wire logic [15:0] desc_idx_in,
	output logic [7:0]       cert_byte_out,
	output logic [7:0]       desc_byte_out,
	output logic             beat_ready_out
);
	logic tog_q = 1'b0;
	always_ff @(posedge clk_in) begin
		tog_q <= ~tog_q;
	end
	assign beat_ready_out = ~(stall_in & tog_q);
	// Patterns never equal to pad bytes at index 0
	assign cert_byte_out = cert_idx_in[7:0] ^ 8'h5a;
	assign desc_byte_out = desc_idx_in[7:0] + 8'h01;
endmodule
`default_nettype wire

// file: sim/spir_asserts.sv
// Purpose: port checks for the responder
// Assumes: default responder parameters
// Notes:   bound into every responder
`timescale 1ns/1ns
`default_nettype none
module spir_asserts (
	input wire logic                clk_in,
	input wire logic                resetn_in,
	input wire spir_pkg::spir_cmd_t cmd_in,
	input wire logic                cmd_valid_in,
	input wire logic                cmd_ready_out,
	input wire logic                cmd_reject_out,
	input wire spir_pkg::spir_beat_t beat_out,
	input wire logic                beat_ready_in,
	input wire logic                done_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	wire logic tk = cmd_valid_in && cmd_ready_out;
	wire logic ok = tk && cmd_in.protocol == 8'h00 && cmd_in.specific <= 16'h2;
	bad_proto_a: assert property (tk && cmd_in.protocol != 8'h00 |=> cmd_reject_out)
		else $error("foreign protocol not rejected");
	bad_code_a: assert property (tk && cmd_in.protocol == 8'h00 && cmd_in.specific > 16'h2 |=> cmd_reject_out)
		else $error("reserved code not rejected");
	good_code_a: assert property (ok |=> !cmd_reject_out)
		else $error("valid request rejected");
	first_beat_a: assert property (ok && cmd_in.alloc_len != 32'h0 |-> ##2 beat_out.valid && beat_out.data == 8'h00)
		else $error("reply does not open with byte 0");
	zero_alloc_a: assert property (ok && cmd_in.alloc_len == 32'h0 |=> !beat_out.valid [*3])
		else $error("beat sent for zero allocation");
	beat_hold_a: assert property (beat_out.valid && !beat_ready_in |=> $stable(beat_out))
		else $error("beat changed while stalled");
	last_done_a: assert property (beat_out.valid && beat_out.last && beat_ready_in |-> ##[1:2] done_out)
		else $error("no done after last beat");
	done_idle_a: assert property (done_out |=> cmd_ready_out && !done_out)
		else $error("not idle after done");
	cover property (ok && cmd_in.specific == 16'h2);
	cover property (cmd_reject_out);
	cover property (beat_out.valid && !beat_ready_in);
endmodule
bind spir_responder spir_asserts chk_u (.clk_in, .resetn_in, .cmd_in,
	.cmd_valid_in, .cmd_ready_out, .cmd_reject_out, .beat_out,
	.beat_ready_in, .done_out);
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: self-checking bench for the responder
// Assumes: default responder parameters
// Notes:   inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import spir_pkg::*;
	logic		clk_in = 1'b0;
	logic		resetn_in = 1'b0;
	logic		cmd_valid_in = 1'b0;
	logic		stall = 1'b0;
	logic [15:0]	cert_len = 16'h0;
	spir_cmd_t	cmd = '0;
	spir_beat_t	beat;
	logic		ready, rej, rdy, done;
	logic [15:0]	cidx, didx;
	logic [7:0]	cbyte, dbyte;
	int		failures = 0;
	int		check_count = 0;
	initial forever #4 clk_in = ~clk_in;
	spir_responder dut_u (.clk_in, .resetn_in, .cmd_in(cmd), .cmd_valid_in,
		.cmd_ready_out(rdy), .cmd_reject_out(rej), .cert_len_in(cert_len),
		.cert_idx_out(cidx), .cert_byte_in(cbyte), .desc_idx_out(didx),
		.desc_byte_in(dbyte), .beat_out(beat), .beat_ready_in(ready),
		.done_out(done));
	spir_host_model host_u (.clk_in, .stall_in(stall), .cert_idx_in(cidx),
		.desc_idx_in(didx), .cert_byte_out(cbyte), .desc_byte_out(dbyte),
		.beat_ready_out(ready));
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// Reply image worked out from header layouts and store patterns
	function automatic logic [7:0] expb(logic [15:0] s, int c, int i);
		logic [95:0] h;
		h = '0;
		if (s == 16'h0) h = {48'h0, 16'h0002, 16'h00ef, 16'h0};
		if (s == 16'h1) h = {16'h0, 16'(c), 64'h0};
		if (s == 16'h2) h = {32'h210, 16'h0001, 16'h0, 32'h208};
		if (s == 16'h1 && i >= 4 && i < 4 + c) return 8'(i - 4) ^ 8'h5a;
		if (s == 16'h2 && i >= 12 && i < 12 + 'h208) return 8'(i - 11);
		return i < 12 ? h[95 - 8 * i -: 8] : 8'h00;
	endfunction
	task automatic xfer(logic [7:0] p, logic [15:0] s, int a, int c, logic er);
		int n;
		logic r;
		logic d;
		n = 0;
		r = 1'b0;
		d = 1'b0;
		cert_len = 16'(c);
		cmd = '{p, s, 32'(a)};
		cmd_valid_in = 1'b1;
		chk(8'(rdy), 8'h01);
		@(negedge clk_in);
		cmd_valid_in = 1'b0;
		for (int k = 0; k < 200; k++) begin
			r |= rej;
			d |= done;
			if (beat.valid && ready) begin
				chk(beat.data, expb(s, c, n));
				chk(8'(beat.last), 8'(n == a - 1));
				n++;
			end
			if (rdy && k > 0) break;
			if (k == 199) begin
				failures++;
				print_verdict;
			end
			@(negedge clk_in);
		end
		chk(8'(n), er ? 8'h00 : 8'(a));
		chk(8'(r), 8'(er));
		chk(8'(d), 8'(!er));
	endtask
	task automatic sc_list;
		xfer(8'h00, 16'h0, 12, 0, 1'b0);
		xfer(8'h00, 16'h0, 7, 0, 1'b0);
	endtask
	task automatic sc_cert;
		// Slow host so stalled beats are held
		stall = 1'b1;
		xfer(8'h00, 16'h1, 12, 5, 1'b0);
		xfer(8'h00, 16'h1, 6, 0, 1'b0);
		stall = 1'b0;
	endtask
	task automatic sc_compl;
		xfer(8'h00, 16'h2, 14, 0, 1'b0);
	endtask
	task automatic sc_refuse;
		xfer(8'h01, 16'h0, 4, 0, 1'b1);
		xfer(8'h00, 16'h3, 4, 0, 1'b1);
		xfer(8'h00, 16'h0, 0, 0, 1'b0);
		xfer(8'h00, 16'h0, 10, 0, 1'b0);
	endtask
	initial begin
		repeat (20) @(negedge clk_in);
		resetn_in = 1'b1;
		repeat (3) @(negedge clk_in);
		sc_list;
		sc_cert;
		sc_compl;
		sc_refuse;
		print_verdict;
	end
endmodule
`default_nettype wire
